/* File: logic/oms_mode_fsm.sv */
// operating-mode state machine with watchdog, restart delay and link frames
// Contract
// - power-up and soft reset enter init mode
// - stop mode keeps main regulator on
// - sleep mode turns main regulator off
// - wake from sleep/fail-safe or failure enters restart
// - restart returns to normal after reset delay
// - critical failure enters fail-safe, main regulator off
// - fail-safe held until wake or overtemperature clears
// - development mode halts the watchdog counter
// - development mode forces CAN normal, aux on
// - debug pin in init selects development mode
// - development mode still allows all modes
// - link frames are sixteen bits wide
// - restart clears the mode field
// - hardware strap picks watchdog failure reaction
// - soft reset loads defaults except locked bits
// - any frame in init moves to normal
// - missed trigger in long window enters restart
// - wake events ignored in init mode
`timescale 1ns/1ps
`default_nettype none
module oms_mode_fsm #(
  parameter int unsigned RD_A_CYC   = oms_pkg::RESET_DELAY_A_CYC,
  parameter int unsigned RD_B_CYC   = oms_pkg::RESET_DELAY_B_CYC,
  parameter int unsigned LONG_CYC   = oms_pkg::LONG_WIN_CYC,
  parameter int unsigned WD_TO_CYC  = oms_pkg::WD_TIMEOUT_CYC
) (
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst_b,
  // link pins
  input  wire logic                 spi_sclk,
  input  wire logic                 spi_cs_b,
  input  wire logic                 spi_mosi,
  output logic                      spi_miso,
  // events and straps
  input  wire logic                 wake_can,
  input  wire logic                 wake_input,
  input  wire logic                 sense_input,
  input  wire logic                 wake_gpio,
  input  wire logic                 main_uv,
  input  wire logic                 overtemp,
  input  wire logic                 debug_entry_pin,
  input  wire logic                 cfg_pullup,
  // supplies and resets
  output logic                      main_regulator_output,
  output logic                      aux_regulator_output,
  output logic                      can_force_normal,
  output logic                      mcu_reset_b,
  // status
  output oms_pkg::oms_state_t       mode_state,
  output logic                      dev_mode,
  output logic [1:0]                operating_mode_field
);
  import oms_pkg::*;

  oms_state_t       st_r;
  oms_state_t       st_nxt;
  logic [CNT_W-1:0] wd_cnt_r;
  logic [CNT_W-1:0] rd_cnt_r;
  logic             cfg_failsafe_r;
  logic             ot_seen_r;
  logic             aux_en_r;
  logic             dly_b_r;
  logic             lock_r;
  logic             frm;
  logic             frm_ok;
  logic [15:0]      frm_word;

  assign mode_state = st_r;

  oms_spi_rx #(.FRAME_BITS(FRAME_BITS)) u_rx (
    .ref_clk     (ref_clk),
    .rst_b       (rst_b),
    .spi_sclk    (spi_sclk),
    .spi_cs_b    (spi_cs_b),
    .spi_mosi    (spi_mosi),
    .spi_miso    (spi_miso),
    .status_word ({operating_mode_field, 3'h0, lock_r, aux_en_r, dly_b_r, 2'h0, st_r}),
    .frame_pulse (frm),
    .frame_ok    (frm_ok),
    .frame_word  (frm_word)
  );

  // frame decode
  wire       wr       = frm & frm_ok & frm_word[WR_BIT];
  wire [6:0] addr     = frm_word[ADDR_MSB:ADDR_LSB];
  wire       msc_wr   = wr && addr == MSC_ADDR;
  wire       wd_trig  = wr && addr == WD_ADDR;
  wire [1:0] req_mode = frm_word[MODE_MSB:MODE_LSB];
  wire       soft_rst = msc_wr && req_mode == MODE_SOFTRST;
  wire       wake_any = wake_can | wake_input | sense_input | wake_gpio;

  // watchdog: long open window in init, timeout in normal
  wire              wd_run  = (st_r == ST_INIT || st_r == ST_NORMAL) && !dev_mode;
  wire [CNT_W-1:0]  wd_lim  = (st_r == ST_INIT) ? CNT_W'(LONG_CYC - 1) : CNT_W'(WD_TO_CYC - 1);
  wire              wd_fail = wd_run && wd_cnt_r >= wd_lim;
  wire oms_state_t  wd_dest = cfg_failsafe_r ? ST_FAILSAFE : ST_RESTART;
  wire [CNT_W-1:0]  rd_lim  = dly_b_r ? CNT_W'(RD_B_CYC - 1) : CNT_W'(RD_A_CYC - 1);
  wire              rd_done = rd_cnt_r >= rd_lim;
  wire              ot_gone = ot_seen_r && !overtemp;

  // requested mode from the controller
  function automatic oms_state_t mode_req(input logic [1:0] m);
    unique case (m)
      MODE_NORMAL: mode_req = ST_NORMAL;
      MODE_SLEEP:  mode_req = ST_SLEEP;
      MODE_STOP:   mode_req = ST_STOP;
      default:     mode_req = ST_INIT;
    endcase
  endfunction : mode_req

  always_comb
  begin
    st_nxt = st_r;
    unique case (st_r)
      ST_INIT:
        if (wd_fail)
          st_nxt = ST_RESTART;
        else if (frm)
          st_nxt = ST_NORMAL;
      ST_NORMAL:
        if (main_uv)
          st_nxt = ST_RESTART;
        else if (wd_fail)
          st_nxt = wd_dest;
        else if (overtemp)
          st_nxt = ST_FAILSAFE;
        else if (msc_wr)
          st_nxt = mode_req(req_mode);
      ST_STOP:
        if (main_uv)
          st_nxt = ST_RESTART;
        else if (overtemp)
          st_nxt = ST_FAILSAFE;
        else if (msc_wr)
          st_nxt = mode_req(req_mode);
        else if (wake_any)
          st_nxt = ST_NORMAL;
      ST_SLEEP:
        if (overtemp)
          st_nxt = ST_FAILSAFE;
        else if (wake_any)
          st_nxt = ST_RESTART;
      ST_RESTART:
        if (overtemp)
          st_nxt = ST_FAILSAFE;
        else if (rd_done && !main_uv)
          st_nxt = ST_NORMAL;
      ST_FAILSAFE:
        if (wake_any || ot_gone)
          st_nxt = ST_RESTART;
      default:
        st_nxt = ST_INIT;
    endcase
  end

  // register fields after the current write
  wire aux_nxt  = soft_rst ? (lock_r ? aux_en_r : AUX_EN_RST)
                : (msc_wr && !lock_r) ? frm_word[AUX_BIT] : aux_en_r;
  wire dly_nxt  = soft_rst ? (lock_r ? dly_b_r : DLY_B_RST)
                : (msc_wr && !lock_r) ? frm_word[DLY_BIT] : dly_b_r;
  wire lock_nxt = lock_r | (msc_wr && !soft_rst && frm_word[LOCK_BIT]);
  wire dev_nxt  = (st_r == ST_INIT) ? debug_entry_pin : dev_mode;
  wire [1:0] fld_nxt = (st_nxt == ST_SLEEP) ? MODE_SLEEP
                     : (st_nxt == ST_STOP) ? MODE_STOP : MODE_NORMAL;

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_r           <= ST_INIT;
      wd_cnt_r       <= '0;
      rd_cnt_r       <= '0;
      cfg_failsafe_r <= 1'b1;
      ot_seen_r      <= 1'b0;
      aux_en_r       <= AUX_EN_RST;
      dly_b_r        <= DLY_B_RST;
      lock_r         <= LOCK_RST;
      dev_mode       <= 1'b0;
    end
    else
    begin
      st_r     <= st_nxt;
      // held at zero from the edge that enters development mode
      wd_cnt_r <= (!wd_run || dev_nxt || wd_trig || st_nxt != st_r) ? '0
                : wd_cnt_r + CNT_W'(1);
      rd_cnt_r <= (st_r == ST_RESTART && !rd_done) ? rd_cnt_r + CNT_W'(1) : rd_cnt_r;
      if (st_r != ST_RESTART)
        rd_cnt_r <= '0;
      if (st_r == ST_INIT)
        cfg_failsafe_r <= ~cfg_pullup;
      ot_seen_r <= (st_r == ST_FAILSAFE) ? (ot_seen_r | overtemp) : overtemp;
      aux_en_r  <= aux_nxt;
      dly_b_r   <= dly_nxt;
      lock_r    <= lock_nxt;
      dev_mode  <= dev_nxt;
    end
  end

  // outputs follow the next state so they stand aligned with mode_state
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      main_regulator_output <= 1'b1;
      aux_regulator_output  <= 1'b0;
      can_force_normal      <= 1'b0;
      mcu_reset_b           <= 1'b1;
      operating_mode_field  <= MODE_NORMAL;
    end
    else
    begin
      main_regulator_output <= st_nxt != ST_SLEEP && st_nxt != ST_FAILSAFE;
      aux_regulator_output  <= dev_nxt | aux_nxt;
      can_force_normal      <= dev_nxt;
      mcu_reset_b           <= st_nxt != ST_RESTART;
      operating_mode_field  <= fld_nxt;
    end
  end

  // restart length monitor, saturating
  logic [CNT_W-1:0] rs_age_r;
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      rs_age_r <= '0;
    else if (st_r != ST_RESTART)
      rs_age_r <= '0;
    else if (rs_age_r != '1)
      rs_age_r <= rs_age_r + CNT_W'(1);
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  soft_reset_a : assert property (st_r == ST_NORMAL && soft_rst && !main_uv && !wd_fail
    && !overtemp |=> st_r == ST_INIT)
    else $error("soft reset did not reach init");
  lock_keep_a : assert property (soft_rst && lock_r
    |=> $stable(aux_en_r) && $stable(dly_b_r))
    else $error("locked bits changed by soft reset");
  stop_main_a : assert property (st_r == ST_STOP |-> main_regulator_output)
    else $error("main regulator off in stop");
  sleep_main_a : assert property (st_r == ST_SLEEP |-> !main_regulator_output)
    else $error("main regulator on in sleep");
  sleep_wake_a : assert property (st_r == ST_SLEEP && wake_any && !overtemp
    |=> st_r == ST_RESTART ##0 !mcu_reset_b)
    else $error("wake from sleep missed restart");
  restart_exit_a : assert property (st_r == ST_RESTART && rd_done && !main_uv
    && !overtemp |=> st_r == ST_NORMAL && mcu_reset_b)
    else $error("restart did not end");
  restart_len_a : assert property (st_r == ST_RESTART && st_nxt == ST_NORMAL
    |-> rs_age_r >= CNT_W'((dly_b_r ? RD_B_CYC : RD_A_CYC) - 1))
    else $error("restart too short");
  failsafe_off_a : assert property (st_r == ST_FAILSAFE |-> !main_regulator_output)
    else $error("main regulator on in fail-safe");
  failsafe_hold_a : assert property (st_r == ST_FAILSAFE && !wake_any && !ot_gone
    |=> st_r == ST_FAILSAFE)
    else $error("fail-safe left without cause");
  wd_halt_a : assert property (dev_mode |-> wd_cnt_r == '0 && !wd_fail)
    else $error("watchdog ran in development mode");
  dev_out_a : assert property (dev_mode |-> can_force_normal && aux_regulator_output)
    else $error("development outputs wrong");
  dev_select_a : assert property (st_r == ST_INIT && debug_entry_pin |=> dev_mode)
    else $error("development mode not selected");
  dev_modes_a : assert property (dev_mode && st_r == ST_NORMAL && msc_wr
    && req_mode == MODE_SLEEP && !main_uv && !overtemp |=> st_r == ST_SLEEP)
    else $error("mode change refused in development mode");
  field_clear_a : assert property (st_r == ST_RESTART
    |-> operating_mode_field == MODE_NORMAL)
    else $error("mode field not cleared in restart");
  wd_cfg_a : assert property (st_r == ST_NORMAL && wd_fail && !main_uv
    |=> st_r == (cfg_failsafe_r ? ST_FAILSAFE : ST_RESTART))
    else $error("watchdog failure reaction wrong");
  init_frame_a : assert property (st_r == ST_INIT && frm && !wd_fail |=> st_r == ST_NORMAL)
    else $error("frame did not leave init");
  init_wd_a : assert property (st_r == ST_INIT && wd_fail |=> st_r == ST_RESTART)
    else $error("long window miss did not restart");
  init_wake_a : assert property (st_r == ST_INIT && !frm && !wd_fail |=> st_r == ST_INIT)
    else $error("init left without frame");
  reset_low_a : assert property (st_r == ST_RESTART |-> !mcu_reset_b)
    else $error("reset released in restart");
  reset_rel_a : assert property (st_r == ST_NORMAL |-> mcu_reset_b)
    else $error("reset held in normal");
  failsafe_wake_a : assert property (st_r == ST_FAILSAFE && wake_any
    |=> st_r == ST_RESTART)
    else $error("wake did not leave fail-safe");
  uv_restart_a : assert property (st_r == ST_NORMAL && main_uv |=> st_r == ST_RESTART)
    else $error("undervoltage did not restart");
  ot_failsafe_a : assert property (st_r == ST_NORMAL && overtemp && !main_uv && !wd_fail
    |=> st_r == ST_FAILSAFE)
    else $error("overtemperature did not enter fail-safe");
  stop_field_a : assert property (st_r == ST_STOP
    |-> operating_mode_field == MODE_STOP)
    else $error("mode field wrong in stop");
  sleep_field_a : assert property (st_r == ST_SLEEP
    |-> operating_mode_field == MODE_SLEEP)
    else $error("mode field wrong in sleep");

  restart_cycle_c : cover property (st_r == ST_RESTART ##1 st_r == ST_NORMAL);
  failsafe_c : cover property (st_r == ST_NORMAL ##1 st_r == ST_FAILSAFE);
  sleep_wake_c : cover property (st_r == ST_SLEEP ##1 st_r == ST_RESTART);
  stop_entry_c : cover property (st_r == ST_NORMAL ##1 st_r == ST_STOP);
  dev_sleep_c : cover property (dev_mode && st_r == ST_SLEEP);
endmodule : oms_mode_fsm
`default_nettype wire

/* File: logic/oms_pkg.sv */
// constants and types of the operating-mode state machine
`default_nettype none
package oms_pkg;
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned CLK_PER_US      = CLK_HZ / 1_000_000;
  // timing figures, in microseconds
  localparam int unsigned RESET_DELAY_A_US = 10_000;
  localparam int unsigned RESET_DELAY_B_US = 2_000;
  localparam int unsigned LONG_WIN_US      = 200_000;
  localparam int unsigned WD_TIMEOUT_US    = 100_000;
  localparam int unsigned RESET_DELAY_A_CYC = RESET_DELAY_A_US * CLK_PER_US;
  localparam int unsigned RESET_DELAY_B_CYC = RESET_DELAY_B_US * CLK_PER_US;
  localparam int unsigned LONG_WIN_CYC      = LONG_WIN_US * CLK_PER_US;
  localparam int unsigned WD_TIMEOUT_CYC    = WD_TIMEOUT_US * CLK_PER_US;
  localparam int unsigned CNT_W             = 24;
  // link frame layout
  localparam int unsigned FRAME_BITS = 16;
  localparam int unsigned WR_BIT     = 15;
  localparam int unsigned ADDR_MSB   = 14;
  localparam int unsigned ADDR_LSB   = 8;
  localparam int unsigned MODE_MSB   = 7;
  localparam int unsigned MODE_LSB   = 6;
  localparam int unsigned LOCK_BIT   = 2;
  localparam int unsigned AUX_BIT    = 1;
  localparam int unsigned DLY_BIT    = 0;
  localparam logic [6:0] MSC_ADDR = 7'h01;
  localparam logic [6:0] WD_ADDR  = 7'h03;
  // operating_mode_field codes
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_SLEEP  = 2'h1;
  localparam logic [1:0] MODE_STOP   = 2'h2;
  localparam logic [1:0] MODE_SOFTRST = 2'h3;
  // values after reset
  localparam logic AUX_EN_RST = 1'b0;
  localparam logic DLY_B_RST  = 1'b0;
  localparam logic LOCK_RST   = 1'b0;
  typedef enum logic [5:0] {
    ST_INIT     = 6'h01,
    ST_NORMAL   = 6'h02,
    ST_STOP     = 6'h04,
    ST_SLEEP    = 6'h08,
    ST_RESTART  = 6'h10,
    ST_FAILSAFE = 6'h20
  } oms_state_t;
endpackage : oms_pkg
`default_nettype wire

/* File: logic/oms_spi_rx.sv */
// 16-bit link frame receiver and status shifter, clock mode 0
`timescale 1ns/1ps
`default_nettype none
module oms_spi_rx #(
  parameter int unsigned FRAME_BITS = oms_pkg::FRAME_BITS
) (
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst_b,
  // link pins
  input  wire logic                  spi_sclk,
  input  wire logic                  spi_cs_b,
  input  wire logic                  spi_mosi,
  output logic                       spi_miso,
  // frame side
  input  wire logic [FRAME_BITS-1:0] status_word,
  output logic                       frame_pulse,
  output logic                       frame_ok,
  output logic [FRAME_BITS-1:0]      frame_word
);
  import oms_pkg::*;
  logic                  sclk_r;
  logic                  cs_b_r;
  logic [4:0]            bit_cnt_r;
  logic [FRAME_BITS-1:0] rx_r;
  logic [FRAME_BITS-1:0] tx_r;
  wire sclk_rise = spi_sclk & ~sclk_r;
  wire sclk_fall = ~spi_sclk & sclk_r;
  wire cs_fall   = ~spi_cs_b & cs_b_r;
  wire cs_rise   = spi_cs_b & ~cs_b_r;
  wire cnt_full  = bit_cnt_r == 5'(FRAME_BITS + 1);

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sclk_r      <= 1'b0;
      cs_b_r      <= 1'b1;
      bit_cnt_r   <= '0;
      rx_r        <= '0;
      tx_r        <= '0;
      frame_pulse <= 1'b0;
      frame_ok    <= 1'b0;
      frame_word  <= '0;
    end
    else
    begin
      sclk_r      <= spi_sclk;
      cs_b_r      <= spi_cs_b;
      frame_pulse <= cs_rise;
      if (cs_fall)
      begin
        bit_cnt_r <= '0;
        tx_r      <= status_word;
      end
      else if (!spi_cs_b && sclk_rise)
      begin
        rx_r <= {rx_r[FRAME_BITS-2:0], spi_mosi};
        if (!cnt_full)
          bit_cnt_r <= bit_cnt_r + 5'h1;
      end
      else if (!spi_cs_b && sclk_fall)
        tx_r <= {tx_r[FRAME_BITS-2:0], 1'b0};
      if (cs_rise)
      begin
        frame_ok   <= bit_cnt_r == 5'(FRAME_BITS);
        frame_word <= rx_r;
      end
    end
  end

  assign spi_miso = tx_r[FRAME_BITS-1];

  frame_len_a : assert property (@(posedge ref_clk) disable iff (!rst_b)
    cs_rise && bit_cnt_r != 5'(FRAME_BITS) |=> frame_pulse && !frame_ok)
    else $error("frame of wrong length accepted");
endmodule : oms_spi_rx
`default_nettype wire

/* File: test/oms_mcu_model.sv */
// microcontroller model acting as master of the 16-bit mode-0 link
`timescale 1ns/1ps
`default_nettype none
module oms_mcu_model (
  // clock
  input  wire logic ref_clk,
  // link pins
  input  wire logic spi_miso,
  output logic      spi_sclk,
  output logic      spi_cs_b,
  output logic      spi_mosi
);
  logic [15:0] rx_word;
  initial
  begin
    spi_sclk = 1'b0;
    spi_cs_b = 1'b1;
    spi_mosi = 1'b0;
    rx_word  = 16'h0000;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  // sends the top nbits of w msb first; hold is the length of each clock phase
  task automatic xfer(input logic [15:0] w, input int nbits, input int hold);
    spi_cs_b = 1'b0;
    for (int i = 15; i > 15 - nbits; i--)
    begin
      spi_mosi = w[i];
      tick(hold);
      spi_sclk = 1'b1;
      rx_word  = {rx_word[14:0], spi_miso};
      tick(hold);
      spi_sclk = 1'b0;
    end
    tick(hold);
    spi_cs_b = 1'b1;
    // released data line must not keep its last value
    spi_mosi = ~spi_mosi;
    tick(3);
  endtask : xfer
endmodule : oms_mcu_model
`default_nettype wire

/* File: test/tb_operating_mode_state_machine.sv */
// self-checking bench of the operating-mode state machine
`timescale 1ns/1ps
`default_nettype none
module tb_operating_mode_state_machine;
  import oms_pkg::*;
  localparam int RDA = 20;
  localparam int RDB = 10;
  localparam int LWC = 600;
  localparam int WDC = 400;
  logic       ref_clk = 1'b0;
  logic       rst_b = 1'b0;
  logic [3:0] wk = 4'h0;
  logic       main_uv = 1'b0;
  logic       overtemp = 1'b0;
  logic       dbg = 1'b0;
  logic       cfg = 1'b0;
  logic       sclk, cs_b, mosi, miso, main_on, aux_on, can_fn, mrst_b, dev;
  logic [1:0] fld;
  oms_state_t st;
  int         fail_count = 0;
  int         n_compared = 0;
  always #10 ref_clk = ~ref_clk;
  oms_mode_fsm #(.RD_A_CYC(RDA), .RD_B_CYC(RDB), .LONG_CYC(LWC), .WD_TO_CYC(WDC)) i_oms_mode_fsm (
    .ref_clk(ref_clk), .rst_b(rst_b), .spi_sclk(sclk), .spi_cs_b(cs_b),
    .spi_mosi(mosi), .spi_miso(miso), .wake_can(wk[0]), .wake_input(wk[1]),
    .sense_input(wk[2]), .wake_gpio(wk[3]), .main_uv(main_uv), .overtemp(overtemp),
    .debug_entry_pin(dbg), .cfg_pullup(cfg), .main_regulator_output(main_on),
    .aux_regulator_output(aux_on), .can_force_normal(can_fn), .mcu_reset_b(mrst_b),
    .mode_state(st), .dev_mode(dev), .operating_mode_field(fld));
  oms_mcu_model i_oms_mcu_model (
    .ref_clk(ref_clk), .spi_miso(miso), .spi_sclk(sclk), .spi_cs_b(cs_b), .spi_mosi(mosi));
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic wrap_up;
    if (fail_count == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic wait_st(input oms_state_t s, input int lim, output int n);
    n = 0;
    while (st !== s)
    begin
      if (n >= lim)
      begin
        check("wait_state", 16'(st), 16'(s));
        wrap_up();
      end
      tick(1);
      n++;
    end
  endtask : wait_st
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    i_oms_mcu_model.xfer({1'b1, a, d}, 16, 2 + int'($urandom_range(1)));
  endtask : wr
  task automatic wake(input int i);
    wk = 4'h1 << i;
    tick(2);
    wk = 4'h0;
    tick(2);
  endtask : wake
  task automatic do_reset(input logic c, input logic d);
    rst_b = 1'b0;
    cfg = c;
    dbg = d;
    tick(10);
    rst_b = 1'b1;
    tick(2);
  endtask : do_reset
  function automatic logic in_win(input int n, input int lim);
    return (n + 5 >= lim) && (n <= lim + 3);
  endfunction : in_win
  initial
  begin
    int n;
    int k;
    k = $urandom(32'hb73d);
    do_reset(1'b0, 1'b0);
    check("init", st, ST_INIT);
    check("mrst_idle", mrst_b, 1'b1);
    wake($urandom_range(3));
    check("init_wake", st, ST_INIT);
    i_oms_mcu_model.xfer(16'($urandom), 7, 2);
    check("any_frame", st, ST_NORMAL);
    wr(MSC_ADDR, {MODE_STOP, 6'h00});
    check("stop", st, ST_STOP);
    check("stop_main", main_on, 1'b1);
    check("stop_fld", fld, MODE_STOP);
    i_oms_mcu_model.xfer({1'b0, MSC_ADDR, 8'h00}, 16, 3);
    check("rd_fld", i_oms_mcu_model.rx_word[15:14], MODE_STOP);
    check("rd_st", i_oms_mcu_model.rx_word[5:0], ST_STOP);
    wake($urandom_range(3));
    check("stop_wake", st, ST_NORMAL);
    for (k = 0; k < 2; k++)
    begin
      wr(MSC_ADDR, {MODE_SLEEP, 5'h00, k[0]});
      check("sleep", st, ST_SLEEP);
      check("sleep_main", main_on, 1'b0);
      check("sleep_fld", fld, MODE_SLEEP);
      wake($urandom_range(3));
      check("restart", st, ST_RESTART);
      check("rst_fld", fld, 2'h0);
      check("rst_out", mrst_b, 1'b0);
      wait_st(ST_NORMAL, RDA + 10, n);
      check("rst_delay", in_win(n, k ? RDB : RDA), 1'b1);
      check("rst_rel", mrst_b, 1'b1);
    end
    main_uv = 1'b1;
    tick(RDA + 10);
    check("uv_hold", st, ST_RESTART);
    main_uv = 1'b0;
    wait_st(ST_NORMAL, RDA + 10, n);
    overtemp = 1'b1;
    tick(3);
    check("ot_fs", st, ST_FAILSAFE);
    tick(5);
    check("ot_hold", st, ST_FAILSAFE);
    overtemp = 1'b0;
    tick(3);
    check("ot_clear", st, ST_RESTART);
    wait_st(ST_NORMAL, RDA + 10, n);
    for (k = 0; k < 4; k++)
    begin
      wr(WD_ADDR, 8'($urandom));
      wait_st(ST_FAILSAFE, WDC + 10, n);
      check("wd_period", n + 10 >= WDC, 1'b1);
      check("fs_main", main_on, 1'b0);
      wake(k);
      check("fs_wake", st, ST_RESTART);
      wait_st(ST_NORMAL, RDA + 10, n);
    end
    wr(MSC_ADDR, 8'h02);
    check("aux_on", aux_on, 1'b1);
    wr(MSC_ADDR, {MODE_SOFTRST, 6'h00});
    check("soft_rst", st, ST_INIT);
    check("aux_dflt", aux_on, 1'b0);
    // read frame, so a random write cannot set the lock bit early
    i_oms_mcu_model.xfer(16'($urandom) & 16'h7fff, 16, 2);
    wr(MSC_ADDR, 8'h06);
    wr(MSC_ADDR, {MODE_SOFTRST, 6'h00});
    check("aux_lock", aux_on, 1'b1);
    do_reset(1'b1, 1'b0);
    wait_st(ST_RESTART, LWC + 10, n);
    check("long_win", n + 10 >= LWC, 1'b1);
    wait_st(ST_NORMAL, RDA + 10, n);
    wait_st(ST_RESTART, WDC + 10, n);
    check("wd_strap", mrst_b, 1'b0);
    wait_st(ST_NORMAL, RDA + 10, n);
    do_reset(1'b0, 1'b1);
    check("dev", dev, 1'b1);
    check("dev_can", can_fn, 1'b1);
    check("dev_aux", aux_on, 1'b1);
    i_oms_mcu_model.xfer(16'($urandom), 16, 2);
    tick(WDC + 50);
    check("dev_wd", st, ST_NORMAL);
    wr(MSC_ADDR, {MODE_SLEEP, 6'h00});
    check("dev_sleep", st, ST_SLEEP);
    wrap_up();
  end
endmodule : tb_operating_mode_state_machine
`default_nettype wire
